// File: rtl/ssw_top.sv
// supply supervisor: reset generator, pushbutton debounce, power-fail warning, watchdog
// assumes analog comparators deliver supply_low and sense_below_ref as async levels
//
// Overview of operation
// - supply comparator reporting low asserts reset at once
// - after supply recovers, reset stays asserted at least 130 ms
// - pushbutton input is active low and debounced before use
// - debounced press asserts reset; 130 ms hold starts on release
// - sense below reference gives one low warning pulse of at least 200 us
// - sense must stay low about 5 us before a warning pulse
// - no warning pulse while supply is still below its trip level
// - watchdog counter idles while reset is asserted
// - each falling kick edge before expiry restarts the full timeout
// - watchdog expires after about 1 s without a falling kick edge
// - on expiry the expired output goes low at least 130 ms
// - reset available active low and active high, same condition
`timescale 1ns/1ps
`default_nettype none
module ssw_top #(
    parameter int unsigned CYC_PER_US     = ssw_pkg::CYC_PER_US,
    parameter int unsigned RST_HOLD_MS    = ssw_pkg::RST_HOLD_MS,
    parameter int unsigned WD_TIMEOUT_MS  = ssw_pkg::WD_TIMEOUT_MS,
    parameter int unsigned WARN_MIN_US    = ssw_pkg::WARN_MIN_US,
    parameter int unsigned SENSE_FILT_CYC = ssw_pkg::SENSE_FILT_CYC,
    parameter int unsigned PB_DEB_CYC     = ssw_pkg::PB_DEB_CYC
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic supply_low,
    input  wire logic pushbutton_reset_n,
    input  wire logic sense_below_ref,
    input  wire logic watchdog_kick_n,
    output var  logic reset_out_n,
    output var  logic reset_out,
    output var  logic power_fail_warn_n,
    output var  logic watchdog_expired_n
);
    // one extra tick absorbs the partial first tick period, so the minimum holds
    localparam int unsigned HOLD_LOAD = RST_HOLD_MS + 1;
    localparam int unsigned WARN_LOAD = WARN_MIN_US + 1;
    localparam int unsigned HW = $clog2(HOLD_LOAD + 1);
    localparam int unsigned UW = $clog2(WARN_LOAD + 1);
    localparam int unsigned FW = $clog2(SENSE_FILT_CYC + 1);
    localparam int unsigned WW = $clog2(WD_TIMEOUT_MS + 1);
    localparam int unsigned DW = $clog2(PB_DEB_CYC + 1);

    typedef struct packed {
        logic [3:0]            s1;
        logic [3:0]            s2;
        logic                  kick_d;
        logic                  pb_deb_n;
        logic [DW-1:0]         deb_cnt;
        logic [FW-1:0]         filt_cnt;
        logic [UW-1:0]         warn_cnt;
        logic [HW-1:0]         hold_cnt;
        ssw_pkg::ssw_wd_state_t wd_st;
        logic [WW-1:0]         wd_cnt;
        logic [HW-1:0]         exp_cnt;
        logic                  rst_n;
        logic                  rst;
        logic                  warn_n;
        logic                  exp_n;
    } ssw_state_t;

    localparam ssw_state_t ST_RESET = '{
        s1:       ssw_pkg::SYNC_RST,
        s2:       ssw_pkg::SYNC_RST,
        kick_d:   1'h1,
        pb_deb_n: 1'h1,
        wd_st:    ssw_pkg::WD_IDLE,
        rst_n:    1'h0,
        rst:      1'h1,
        warn_n:   1'h1,
        exp_n:    1'h1,
        default:  '0
    };

    ssw_state_t st_ff;
    ssw_state_t nxt_st;
    logic       cause;
    logic       fire;
    logic       kick_fall;

    ssw_tick_if tk ();

    ssw_timebase #(
        .CYC_PER_US (CYC_PER_US),
        .US_PER_MS  (ssw_pkg::US_PER_MS)
    ) u_timebase (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .tk      (tk)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {watchdog_kick_n, sense_below_ref, pushbutton_reset_n, supply_low};
        nxt_st.s2 = st_ff.s1;

        if (st_ff.s2[ssw_pkg::SY_PB] == st_ff.pb_deb_n) begin
            nxt_st.deb_cnt = '0;
        end else if (st_ff.deb_cnt == DW'(PB_DEB_CYC - 1)) begin
            nxt_st.deb_cnt = '0;
            nxt_st.pb_deb_n = st_ff.s2[ssw_pkg::SY_PB];
        end else begin
            nxt_st.deb_cnt = st_ff.deb_cnt + 1'h1;
        end

        cause = st_ff.s2[ssw_pkg::SY_SUPPLY] | ~st_ff.pb_deb_n;
        if (cause) begin
            nxt_st.hold_cnt = HW'(HOLD_LOAD);
        end else if (tk.tick_ms && st_ff.hold_cnt != '0) begin
            nxt_st.hold_cnt = st_ff.hold_cnt - 1'h1;
        end
        nxt_st.rst = cause | (st_ff.hold_cnt != '0);
        nxt_st.rst_n = ~nxt_st.rst;

        // persistence filter; held clear while supply low so a late pulse still comes
        if (!st_ff.s2[ssw_pkg::SY_SENSE] || st_ff.s2[ssw_pkg::SY_SUPPLY]) begin
            nxt_st.filt_cnt = '0;
        end else if (st_ff.filt_cnt != FW'(SENSE_FILT_CYC)) begin
            nxt_st.filt_cnt = st_ff.filt_cnt + 1'h1;
        end
        // supply gate; one pulse per low episode since the filter saturates
        fire = st_ff.s2[ssw_pkg::SY_SENSE] && (st_ff.filt_cnt == FW'(SENSE_FILT_CYC - 1))
               && !st_ff.s2[ssw_pkg::SY_SUPPLY];
        if (fire) begin
            nxt_st.warn_cnt = UW'(WARN_LOAD);
        end else if (tk.tick_us && st_ff.warn_cnt != '0) begin
            nxt_st.warn_cnt = st_ff.warn_cnt - 1'h1;
        end
        nxt_st.warn_n = ~(fire | (st_ff.warn_cnt != '0));

        nxt_st.kick_d = st_ff.s2[ssw_pkg::SY_KICK];
        kick_fall = st_ff.kick_d & ~st_ff.s2[ssw_pkg::SY_KICK];

        unique case (st_ff.wd_st)
            ssw_pkg::WD_IDLE: begin
                nxt_st.wd_cnt = '0;
                if (!st_ff.rst) begin
                    nxt_st.wd_st = ssw_pkg::WD_RUN;
                end
            end
            ssw_pkg::WD_RUN: begin
                if (st_ff.rst) begin
                    nxt_st.wd_st = ssw_pkg::WD_IDLE;
                    nxt_st.wd_cnt = '0;
                end else if (kick_fall) begin
                    nxt_st.wd_cnt = '0;
                end else if (tk.tick_ms) begin
                    if (st_ff.wd_cnt == WW'(WD_TIMEOUT_MS)) begin
                        nxt_st.wd_st = ssw_pkg::WD_EXP;
                        nxt_st.wd_cnt = '0;
                        nxt_st.exp_cnt = HW'(HOLD_LOAD);
                    end else begin
                        nxt_st.wd_cnt = st_ff.wd_cnt + 1'h1;
                    end
                end
            end
            ssw_pkg::WD_EXP: begin
                // expired pulse length; kicks are ignored meanwhile
                if (st_ff.exp_cnt == '0) begin
                    nxt_st.wd_st = ssw_pkg::WD_RUN;
                end else if (tk.tick_ms) begin
                    nxt_st.exp_cnt = st_ff.exp_cnt - 1'h1;
                end
            end
            default: begin
                // unused code: fall back to idle
                nxt_st.wd_st = ssw_pkg::WD_IDLE;
                nxt_st.wd_cnt = '0;
            end
        endcase
        nxt_st.exp_n = (nxt_st.wd_st != ssw_pkg::WD_EXP);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reset_out_n        = st_ff.rst_n;
    assign reset_out          = st_ff.rst;
    assign power_fail_warn_n  = st_ff.warn_n;
    assign watchdog_expired_n = st_ff.exp_n;

    sequence s_warn_held;
        !st_ff.warn_n [*8];
    endsequence
    sequence s_exp_held;
        !st_ff.exp_n [*8];
    endsequence

    property p_supply_rst;
        @(posedge ref_clk) disable iff (!arst_n)
        st_ff.s2[ssw_pkg::SY_SUPPLY] |=> !st_ff.rst_n;
    endproperty
    a_supply_rst: assert property (p_supply_rst) else $error("supply low without reset");

    property p_release;
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(st_ff.rst_n) |-> $past(st_ff.hold_cnt) == '0 && !$past(cause);
    endproperty
    a_release: assert property (p_release) else $error("reset released before hold done");

    property p_button;
        @(posedge ref_clk) disable iff (!arst_n)
        !st_ff.pb_deb_n |=> !st_ff.rst_n && st_ff.hold_cnt == HW'(HOLD_LOAD);
    endproperty
    a_button: assert property (p_button) else $error("press did not hold reset");

    property p_restart;
        @(posedge ref_clk) disable iff (!arst_n)
        cause && st_ff.hold_cnt != '0 |=> st_ff.hold_cnt == HW'(HOLD_LOAD);
    endproperty
    a_restart: assert property (p_restart) else $error("hold not restarted");

    property p_polarity;
        @(posedge ref_clk) disable iff (!arst_n)
        st_ff.rst == !st_ff.rst_n;
    endproperty
    a_polarity: assert property (p_polarity) else $error("reset outputs disagree");

    property p_warn_len;
        @(posedge ref_clk) disable iff (!arst_n)
        $fell(st_ff.warn_n) |-> s_warn_held;
    endproperty
    a_warn_len: assert property (p_warn_len) else $error("warning pulse too short");

    property p_filter;
        @(posedge ref_clk) disable iff (!arst_n)
        $fell(st_ff.warn_n) |-> st_ff.filt_cnt == FW'(SENSE_FILT_CYC) && $past(st_ff.s2[ssw_pkg::SY_SENSE]);
    endproperty
    a_filter: assert property (p_filter) else $error("warning without persistence");

    property p_gate;
        @(posedge ref_clk) disable iff (!arst_n)
        $fell(st_ff.warn_n) |-> !$past(st_ff.s2[ssw_pkg::SY_SUPPLY]);
    endproperty
    a_gate: assert property (p_gate) else $error("warning while supply low");

    property p_wd_idle;
        @(posedge ref_clk) disable iff (!arst_n)
        st_ff.rst |=> st_ff.wd_cnt == '0;
    endproperty
    a_wd_idle: assert property (p_wd_idle) else $error("watchdog counted under reset");

    property p_kick;
        @(posedge ref_clk) disable iff (!arst_n)
        kick_fall && st_ff.wd_st == ssw_pkg::WD_RUN |=> st_ff.wd_cnt == '0 && st_ff.exp_n;
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not restart watchdog");

    property p_timeout;
        @(posedge ref_clk) disable iff (!arst_n)
        $fell(st_ff.exp_n) |-> $past(st_ff.wd_cnt) == WW'(WD_TIMEOUT_MS) && $past(tk.tick_ms);
    endproperty
    a_timeout: assert property (p_timeout) else $error("expiry at wrong count");

    property p_exp_len;
        @(posedge ref_clk) disable iff (!arst_n)
        $fell(st_ff.exp_n) |-> s_exp_held;
    endproperty
    a_exp_len: assert property (p_exp_len) else $error("expired pulse too short");

endmodule // ssw_top
`default_nettype wire

// File: rtl/ssw_pkg.sv
// constants of the supply supervisor and watchdog
// assumes a single 50 MHz reference clock; all times derive from it
package ssw_pkg;

    localparam int unsigned CLK_HZ        = 32'h02FA_F080; // 50 MHz
    localparam int unsigned CLK_PERIOD_NS = 32'h0000_0014; // 20 ns
    localparam int unsigned NS_PER_US     = 32'h0000_03E8;
    localparam int unsigned US_PER_MS     = 32'h0000_03E8;
    localparam int unsigned HZ_PER_MHZ    = 32'h000F_4240;

    localparam int unsigned RST_HOLD_MS   = 32'h0000_0082; // 130 ms
    localparam int unsigned WD_TIMEOUT_MS = 32'h0000_03E8; // 1 s
    localparam int unsigned WARN_MIN_US   = 32'h0000_00C8; // 200 us
    localparam int unsigned SENSE_FILT_US = 32'h0000_0005; // 5 us
    localparam int unsigned PB_DEB_NS     = 32'h0000_0096; // 150 ns

    localparam int unsigned CYC_PER_US     = CLK_HZ / HZ_PER_MHZ;
    // roughly 5 us of persistence, rounded down
    localparam int unsigned SENSE_FILT_CYC = (SENSE_FILT_US * NS_PER_US) / CLK_PERIOD_NS;
    // least time, rounded up
    localparam int unsigned PB_DEB_CYC     = (PB_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // synchroniser reset: supply low, button released, sense not below reference, kick high
    localparam logic [3:0] SYNC_RST = 4'hB;
    localparam int unsigned SY_SUPPLY = 0;
    localparam int unsigned SY_PB     = 1;
    localparam int unsigned SY_SENSE  = 2;
    localparam int unsigned SY_KICK   = 3;

    typedef enum logic [1:0] {
        WD_IDLE = 2'h0,
        WD_RUN  = 2'h1,
        WD_EXP  = 2'h3
    } ssw_wd_state_t;

endpackage

// File: rtl/ssw_tick_if.sv
// timebase ticks passed from the divider to the supervisor
// both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface ssw_tick_if;
    logic tick_us;
    logic tick_ms;
    modport src (output tick_us, output tick_ms);
    modport dst (input tick_us, input tick_ms);
endinterface
`default_nettype wire

// File: rtl/ssw_timebase.sv
// divider producing one-cycle microsecond and millisecond enables
// assumes ref_clk at the package rate
`timescale 1ns/1ps
`default_nettype none
module ssw_timebase #(
    parameter int unsigned CYC_PER_US = ssw_pkg::CYC_PER_US,
    parameter int unsigned US_PER_MS  = ssw_pkg::US_PER_MS
) (
    input  wire logic   ref_clk,
    input  wire logic   arst_n,
    ssw_tick_if.src     tk
);
    localparam int unsigned CW = $clog2(CYC_PER_US + 1);
    localparam int unsigned MW = $clog2(US_PER_MS + 1);

    typedef struct packed {
        logic [CW-1:0] cyc;
        logic [MW-1:0] us;
        logic          tick_us;
        logic          tick_ms;
    } ssw_tb_state_t;

    ssw_tb_state_t st_ff;
    ssw_tb_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick_us = 1'h0;
        nxt_st.tick_ms = 1'h0;
        if (st_ff.cyc == CW'(CYC_PER_US - 1)) begin
            nxt_st.cyc = '0;
            nxt_st.tick_us = 1'h1;
            if (st_ff.us == MW'(US_PER_MS - 1)) begin
                nxt_st.us = '0;
                nxt_st.tick_ms = 1'h1;
            end else begin
                nxt_st.us = st_ff.us + 1'h1;
            end
        end else begin
            nxt_st.cyc = st_ff.cyc + 1'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tk.tick_us = st_ff.tick_us;
    assign tk.tick_ms = st_ff.tick_ms;

    property p_ms_on_us;
        @(posedge ref_clk) disable iff (!arst_n)
        st_ff.tick_ms |-> st_ff.tick_us;
    endproperty
    a_ms_on_us: assert property (p_ms_on_us) else $error("ms tick without us tick");

endmodule // ssw_timebase
`default_nettype wire

// File: sim/ssw_host_model.sv
// host side model: drives the watchdog strobe with falling-edge kicks
// assumes the bench enables it and that ref_clk runs throughout
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model #(
    parameter int unsigned PERIOD_CYC = 4000
) (
    input  wire logic ref_clk,
    input  wire logic kick_en,
    output var  logic watchdog_kick_n
);
    initial begin
        watchdog_kick_n = 1'b1;
        forever begin
            repeat (PERIOD_CYC) @(negedge ref_clk);
            // enable checked late so no stray kick lands after disable
            if (kick_en) begin
                watchdog_kick_n = 1'b0;
                repeat (3) @(negedge ref_clk);
                watchdog_kick_n = 1'b1;
            end
        end
    end
endmodule // ssw_host_model
`default_nettype wire

// File: sim/tb_supply_supervisor_watchdog.sv
// self-checking bench of the supervisor with shortened timebase
// assumes the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ev, gv) begin checks++; if ((gv) !== (ev)) begin fail_count++; $display("MISMATCH %s exp %0h got %0h", nm, ev, gv); end end
module tb_supply_supervisor_watchdog;
    localparam int US   = 2;
    localparam int MS   = US * 1000;
    localparam int HOLD = 2;
    localparam int WD   = 4;
    localparam int WARN = 10;
    localparam int FILT = 10;

    logic ref_clk;
    logic arst_n;
    logic supply_low;
    logic pushbutton_reset_n;
    logic sense_below_ref;
    logic watchdog_kick_n;
    logic kick_en;
    logic reset_out_n;
    logic reset_out;
    logic power_fail_warn_n;
    logic watchdog_expired_n;
    int   fail_count;
    int   checks;
    int   n;

    ssw_top #(
        .CYC_PER_US     (US),
        .RST_HOLD_MS    (HOLD),
        .WD_TIMEOUT_MS  (WD),
        .WARN_MIN_US    (WARN),
        .SENSE_FILT_CYC (FILT),
        .PB_DEB_CYC     (8)
    ) DUT (
        .ref_clk            (ref_clk),
        .arst_n             (arst_n),
        .supply_low         (supply_low),
        .pushbutton_reset_n (pushbutton_reset_n),
        .sense_below_ref    (sense_below_ref),
        .watchdog_kick_n    (watchdog_kick_n),
        .reset_out_n        (reset_out_n),
        .reset_out          (reset_out),
        .power_fail_warn_n  (power_fail_warn_n),
        .watchdog_expired_n (watchdog_expired_n)
    );

    // kick period kept well under the shortened timeout
    ssw_host_model #(.PERIOD_CYC(MS * WD / 2)) host (
        .ref_clk         (ref_clk),
        .kick_en         (kick_en),
        .watchdog_kick_n (watchdog_kick_n)
    );

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    always @(negedge ref_clk) begin
        if (arst_n) `CHK("reset_pair", ~reset_out_n, reset_out)
    end

    function automatic logic sig(input int w);
        case (w)
            0: return reset_out_n;
            1: return power_fail_warn_n;
            default: return watchdog_expired_n;
        endcase
    endfunction

    function automatic logic in_rng(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi);
    endfunction

    // counts cycles while the chosen output stays at lvl, bounded by lim
    task automatic hold_n(input int w, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (sig(w) === lvl && cnt < lim) begin
            @(negedge ref_clk);
            cnt++;
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_powerup();
        hold_n(0, 1'b0, MS * (HOLD + 1) + 64, n);
        `CHK("powerup_hold", 1'b1, in_rng(n, MS * HOLD, MS * (HOLD + 1) + 16))
    endtask

    task automatic t_supply();
        supply_low = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK("supply_reset", 1'b0, reset_out_n)
        sense_below_ref = 1'b1;
        hold_n(1, 1'b1, 40, n);
        `CHK("warn_suppressed", 40, n)
        repeat (1000) @(negedge ref_clk);
        supply_low = 1'b0;
        hold_n(1, 1'b1, FILT + 16, n);
        `CHK("warn_after_supply", 1'b1, in_rng(n, FILT, FILT + 6))
        sense_below_ref = 1'b0;
        repeat (1000) @(negedge ref_clk);
        supply_low = 1'b1;
        repeat (5) @(negedge ref_clk);
        supply_low = 1'b0;
        hold_n(0, 1'b0, MS * (HOLD + 1) + 64, n);
        `CHK("supply_hold", 1'b1, in_rng(n, MS * HOLD, MS * (HOLD + 1) + 16))
    endtask

    task automatic t_button();
        pushbutton_reset_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        pushbutton_reset_n = 1'b1;
        hold_n(0, 1'b1, 30, n);
        `CHK("short_press", 30, n)
        pushbutton_reset_n = 1'b0;
        repeat (14) @(negedge ref_clk);
        `CHK("press_reset", 1'b0, reset_out_n)
        repeat (MS * (HOLD + 2)) @(negedge ref_clk);
        `CHK("held_reset", 1'b0, reset_out_n)
        pushbutton_reset_n = 1'b1;
        hold_n(0, 1'b0, MS * (HOLD + 1) + 64, n);
        `CHK("release_hold", 1'b1, in_rng(n, MS * HOLD, MS * (HOLD + 1) + 24))
    endtask

    task automatic t_warn();
        sense_below_ref = 1'b1;
        repeat (6) @(negedge ref_clk);
        sense_below_ref = 1'b0;
        hold_n(1, 1'b1, 40, n);
        `CHK("noise_reject", 40, n)
        sense_below_ref = 1'b1;
        hold_n(1, 1'b1, FILT + 16, n);
        `CHK("warn_delay", 1'b1, in_rng(n, FILT, FILT + 6))
        hold_n(1, 1'b0, 200, n);
        `CHK("warn_width", 1'b1, in_rng(n, US * WARN, US * (WARN + 1) + 2))
        hold_n(1, 1'b1, 100, n);
        `CHK("single_pulse", 100, n)
        sense_below_ref = 1'b0;
    endtask

    task automatic t_watchdog();
        hold_n(2, 1'b1, 2 * MS * WD, n);
        `CHK("kicked_alive", 2 * MS * WD, n)
        kick_en = 1'b0;
        pushbutton_reset_n = 1'b0;
        repeat (20) @(negedge ref_clk);
        pushbutton_reset_n = 1'b1;
        hold_n(0, 1'b0, MS * (HOLD + 1) + 64, n);
        hold_n(2, 1'b1, MS * (WD + 1) + 32, n);
        `CHK("wd_timeout", 1'b1, in_rng(n, MS * WD, MS * (WD + 1) + 16))
        hold_n(2, 1'b0, MS * (HOLD + 1) + 64, n);
        `CHK("wd_width", 1'b1, in_rng(n, MS * HOLD, MS * (HOLD + 1) + 16))
    endtask

    initial begin
        #(90000 * 20);
        fail_count++;
        finish_test();
    end

    initial begin
        fail_count = 0;
        checks = 0;
        arst_n = 1'b0;
        supply_low = 1'b0;
        pushbutton_reset_n = 1'b1;
        sense_below_ref = 1'b0;
        kick_en = 1'b1;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        t_powerup();
        t_supply();
        t_button();
        t_warn();
        t_watchdog();
        finish_test();
    end
endmodule // tb_supply_supervisor_watchdog
`default_nettype wire
